// file: hdl/heatseal_map.vh
// Register map, field positions, reset values and timing counts
`ifndef HEATSEAL_MAP_VH
`define HEATSEAL_MAP_VH

`define CLK_HZ 10000000
`define TICK_FINE_NS 100000
`define TICK_COARSE_US 100000

`define A_CTRL 8'h00
`define A_LIMITS 8'h04
`define A_TIMES 8'h08
`define A_MEAS 8'h0c
`define A_SETPT 8'h10
`define A_STATUS 8'h14
`define A_CYCIN 8'h18
`define A_CLEAR 8'h1c

`define F_DIAG 0
`define F_DPV1 1
`define F_FMT 2
`define F_ERRFMT 3
`define F_COMP 5:4
`define F_TDIAG 6
`define F_HOLD 9:8
`define CTRL_RST 10'h001

`define LIM_RST 8'h0a
`define MEAS_RST 5'h11
`define MEAS_MIN 5'h11
`define MEAS_MAX 5'h1e

`define COMP_OFF 2'h0
`define COMP_ON 2'h1
`define COMP_AUTO 2'h2
`define HOLD_OFF 2'h0
`define HOLD_ON 2'h1
`define HOLD_2S 2'h2

`define CAL_GAP_TICKS 8'h14
`define COMP_AUTO_TICKS 8'h14
`define HOLD_TICKS 8'h14

`define ERR_NONE 10'h000
`define ERR_HEATUP 10'h130
`define ERR_HIGH 10'h133
`define ERR_LOW 10'h134
`define ERR_NOARM_LOW 10'h135
`define ERR_NOARM_HIGH 10'h136

`endif

// file: hdl/tick_gen.v
// Divider making the 100 us and 100 ms enable pulses
`timescale 1ns/1ps
`default_nettype none
module tick_gen #(
    parameter integer FINE_CYC = 1000,
    parameter integer COARSE_DIV = 1000
) (
    input wire hclk,
    input wire hresetn,
    output reg tick_fine,
    output reg tick_coarse
);
    reg [15:0] fine_cnt_r;
    reg [15:0] coarse_cnt_r;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fine_cnt_r <= 16'h0000;
            coarse_cnt_r <= 16'h0000;
            tick_fine <= 1'b0;
            tick_coarse <= 1'b0;
        end else begin
            tick_fine <= 1'b0;
            tick_coarse <= 1'b0;
            if (fine_cnt_r == FINE_CYC[15:0] - 16'h0001) begin
                fine_cnt_r <= 16'h0000;
                tick_fine <= 1'b1;
                if (coarse_cnt_r == COARSE_DIV[15:0] - 16'h0001) begin
                    coarse_cnt_r <= 16'h0000;
                    tick_coarse <= 1'b1;
                end else begin
                    coarse_cnt_r <= coarse_cnt_r + 16'h0001;
                end
            end else begin
                fine_cnt_r <= fine_cnt_r + 16'h0001;
            end
        end
    end
endmodule
`default_nettype wire

// file: hdl/heatseal_supervisor.v
// Parameter supervision of a heatsealing controller, AHB-Lite slave
// Functional notes
// [RULE1] DPV1 mode: parameter gates interrupt, not legacy diagnostics
// [RULE2] Measuring impulse length follows its parameter
// [RULE3] Cyclic words byte-swapped per data format
// [RULE4] Error field 4-bit coarse or 10-bit detailed
// [RULE5] Compensation off never compensates
// [RULE6] Mode on: quick second calibration compensates
// [RULE7] Mode on: slow second calibration stays plain
// [RULE8] Mode auto: compensate after each good calibration
// [RULE9] Compensating: blink indicator, analog output zero
// [RULE10] Diagnosis compares actual against set tolerance band
// [RULE11] Armed at start; leaving band gives 307/308
// [RULE12] Not armed at start end gives 309/310
// [RULE13] Delay postpones arming after lower limit crossing
// [RULE14] Heatup timeout: 95 percent not reached gives 304
// [RULE15] Heatup timeout off unless master enables it
// [RULE16] Hold off reports live temperature
// [RULE17] Hold on reports value at last phase end
// [RULE18] Hold 2s freezes two seconds, then live
// [RULE19] Analog output live except zero while compensating, hold digital only
// [RULE20] Master alone sets tolerance limits
// [RULE21] Counters use 100 ms tick, clear at start end
`timescale 1ns/1ps
`default_nettype none
`include "heatseal_map.vh"
module heatseal_supervisor #(
    parameter integer FINE_CYC = `CLK_HZ / 1000 * `TICK_FINE_NS / 1000000,
    parameter integer COARSE_DIV = `TICK_COARSE_US * 1000 / `TICK_FINE_NS
) (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire hreadyout,
    output wire hresp,
    output reg [31:0] hrdata,
    input wire start_pin,
    input wire [9:0] actual_temp,
    input wire heat_on,
    input wire meas_req,
    input wire cal_start,
    input wire cal_done,
    output reg meas_impulse,
    output reg alarm_relay,
    output reg comp_active,
    output wire led_output,
    output reg [9:0] analog_actual,
    output reg [9:0] display_temp,
    output wire ext_diag_en,
    output wire dpv1_diag_int_en
);
    reg [9:0] ctrl_r;
    reg [7:0] lim_lo_r;
    reg [7:0] lim_hi_r;
    reg [6:0] delay_r;
    reg [9:0] heatup_r;
    reg [4:0] meas_r;
    reg [15:0] setpt_raw_r;
    reg [9:0] err_r;
    reg armed_r;
    reg start_s1_r, start_s2_r, start_d_r;
    reg [7:0] wr_addr_r;
    reg wr_pend_r;
    wire tick_fine, tick_coarse;

    // Swap serves both directions of the cyclic data
    function [15:0] order16;
        input [15:0] w;
        input swap_en;
        begin
            order16 = swap_en ? {w[7:0], w[15:8]} : w; // see [RULE3]
        end
    endfunction

    // Coarse form keeps only the hundreds digit
    function [9:0] err_field;
        input [9:0] code;
        input wide;
        begin
            if (wide)
                err_field = code; // see [RULE4]
            else if (code == `ERR_NONE)
                err_field = 10'h000;
            else
                err_field = {6'h00, 4'h3}; // see [RULE4]
        end
    endfunction

    tick_gen #(.FINE_CYC(FINE_CYC), .COARSE_DIV(COARSE_DIV)) u_tick (
        .hclk(hclk),
        .hresetn(hresetn),
        .tick_fine(tick_fine),
        .tick_coarse(tick_coarse)
    );

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign ext_diag_en = ctrl_r[`F_DIAG] & ~ctrl_r[`F_DPV1]; // see [RULE1]
    assign dpv1_diag_int_en = ctrl_r[`F_DIAG] & ctrl_r[`F_DPV1]; // see [RULE1]

    wire swap_en = ctrl_r[`F_FMT];
    wire [15:0] setpt_word = order16(setpt_raw_r, swap_en);
    wire [9:0] set_temp = setpt_word[9:0];
    wire addr_ok = hsel & htrans[1] & hready;
    wire clr_wr = wr_pend_r & (wr_addr_r == `A_CLEAR) & hwdata[0];

    // Band limits come only from the bus registers  see [RULE20]
    wire [10:0] band_lo = ({1'b0, set_temp} > {3'h0, lim_lo_r}) ?
        ({1'b0, set_temp} - {3'h0, lim_lo_r}) : 11'h000;
    wire [10:0] band_hi = {1'b0, set_temp} + {3'h0, lim_hi_r};
    wire above_lo = {1'b0, actual_temp} >= band_lo; // see [RULE10]
    wire below_hi = {1'b0, actual_temp} <= band_hi; // see [RULE10]
    wire in_band = above_lo & below_hi; // see [RULE10]
    wire [14:0] act_x20 = {1'b0, actual_temp, 4'h0} +
        {3'h0, actual_temp, 2'h0};
    wire reach95 = act_x20 >= {1'b0, set_temp, 4'h0} +
        {4'h0, set_temp, 1'b0} + {5'h0, set_temp}; // see [RULE14]

    wire start_rise = start_s2_r & ~start_d_r;
    wire start_fall = ~start_s2_r & start_d_r;
    wire [1:0] alarm_r_bits = {alarm_relay, alarm_relay};

    // Register access; hrdata is loaded in the address phase, so a read
    // right behind a write to the same register returns the old value.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
            ctrl_r <= `CTRL_RST;
            lim_lo_r <= `LIM_RST;
            lim_hi_r <= `LIM_RST;
            delay_r <= 7'h00;
            heatup_r <= 10'h000;
            meas_r <= `MEAS_RST;
            setpt_raw_r <= 16'h0000;
        end else begin
            wr_pend_r <= addr_ok & hwrite;
            if (addr_ok)
                wr_addr_r <= haddr[7:0];
            if (addr_ok & ~hwrite) begin
                case (haddr[7:0])
                    `A_CTRL: hrdata <= {22'h000000, ctrl_r};
                    `A_LIMITS: hrdata <= {16'h0000, lim_hi_r, lim_lo_r};
                    `A_TIMES: hrdata <= {6'h00, heatup_r, 9'h000, delay_r};
                    `A_MEAS: hrdata <= {27'h0000000, meas_r};
                    `A_SETPT: hrdata <= {16'h0000, setpt_raw_r};
                    `A_STATUS: hrdata <= {16'h0000, comp_active, armed_r,
                        alarm_r_bits, 2'h0, err_field(err_r,
                        ctrl_r[`F_ERRFMT])};
                    `A_CYCIN: hrdata <= {16'h0000,
                        order16({6'h00, display_temp}, swap_en)};
                    default: hrdata <= 32'h00000000;
                endcase
            end
            if (wr_pend_r) begin
                case (wr_addr_r)
                    `A_CTRL: ctrl_r <= hwdata[9:0];
                    `A_LIMITS: begin
                        lim_lo_r <= hwdata[7:0];
                        lim_hi_r <= hwdata[15:8];
                    end
                    `A_TIMES: begin
                        delay_r <= (hwdata[6:0] > 7'h63) ? 7'h63 :
                            hwdata[6:0];
                        heatup_r <= (hwdata[25:16] > 10'h3e7) ? 10'h3e7 :
                            hwdata[25:16]; // see [RULE15]
                    end
                    `A_MEAS: meas_r <= hwdata[4:0];
                    `A_SETPT: setpt_raw_r <= hwdata[15:0];
                    default: ;
                endcase
            end
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            start_s1_r <= 1'b0;
            start_s2_r <= 1'b0;
            start_d_r <= 1'b0;
        end else begin
            start_s1_r <= start_pin;
            start_s2_r <= start_s1_r;
            start_d_r <= start_s2_r;
        end
    end

    // Measuring impulse, counted in 100 us steps; starts at once but
    // ends up to one step short because it counts on the shared divider.
    reg [4:0] meas_cnt_r;
    wire [4:0] meas_len = (meas_r < `MEAS_MIN) ? `MEAS_MIN :
        (meas_r > `MEAS_MAX) ? `MEAS_MAX : meas_r;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meas_impulse <= 1'b0;
            meas_cnt_r <= 5'h00;
        end else if (!meas_impulse) begin
            if (meas_req) begin
                meas_impulse <= 1'b1;
                meas_cnt_r <= 5'h00;
            end
        end else if (tick_fine) begin
            if (meas_cnt_r == meas_len - 5'h01)
                meas_impulse <= 1'b0; // see [RULE2]
            else
                meas_cnt_r <= meas_cnt_r + 5'h01;
        end
    end

    // Temperature diagnosis and heatup timeout
    reg [6:0] dly_cnt_r;
    reg dly_run_r;
    reg [9:0] heat_cnt_r;
    reg reached_r;
    wire diag_on = ctrl_r[`F_TDIAG];
    wire heat_on_en = heatup_r != 10'h000;
    reg [9:0] err_nxt;
    always @* begin
        err_nxt = `ERR_NONE;
        if (diag_on & start_s2_r & armed_r & ~in_band)
            err_nxt = above_lo ? `ERR_HIGH : `ERR_LOW; // see [RULE11]
        else if (diag_on & start_fall & ~armed_r)
            err_nxt = above_lo ? `ERR_NOARM_HIGH : `ERR_NOARM_LOW; // see [RULE12]
        else if (heat_on_en & start_s2_r & ~reached_r & ~reach95 &
                 heat_cnt_r >= heatup_r)
            err_nxt = `ERR_HEATUP; // see [RULE14]
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            armed_r <= 1'b0;
            dly_run_r <= 1'b0;
            dly_cnt_r <= 7'h00;
            heat_cnt_r <= 10'h000;
            reached_r <= 1'b0;
            err_r <= `ERR_NONE;
            alarm_relay <= 1'b0;
        end else begin
            if (!start_s2_r) begin
                armed_r <= 1'b0; // see [RULE21]
                dly_run_r <= 1'b0;
                dly_cnt_r <= 7'h00;
                heat_cnt_r <= 10'h000;
                reached_r <= 1'b0;
            end else begin
                if (start_rise & in_band & delay_r == 7'h00)
                    armed_r <= 1'b1; // see [RULE11]
                if (above_lo & ~dly_run_r)
                    dly_run_r <= 1'b1; // see [RULE13]
                if (dly_run_r & tick_coarse & dly_cnt_r != delay_r)
                    dly_cnt_r <= dly_cnt_r + 7'h01; // see [RULE21]
                if (dly_run_r & dly_cnt_r == delay_r & in_band)
                    armed_r <= 1'b1; // see [RULE13]
                if (reach95)
                    reached_r <= 1'b1;
                if (tick_coarse & heat_cnt_r != 10'h3ff)
                    heat_cnt_r <= heat_cnt_r + 10'h001; // see [RULE14]
            end
            // A new error in the clearing cycle wins over the clear
            if (err_nxt != `ERR_NONE & (err_r == `ERR_NONE | clr_wr)) begin
                err_r <= err_nxt;
                alarm_relay <= 1'b1;
            end else if (clr_wr) begin
                err_r <= `ERR_NONE;
                alarm_relay <= 1'b0;
            end
        end
    end

    // Phase-angle compensation around zero calibration
    reg [7:0] gap_cnt_r;
    reg gap_valid_r;
    reg in_cal_r;
    reg [7:0] comp_cnt_r;
    reg comp_timed_r;
    reg blink_r;
    wire [1:0] comp_mode = ctrl_r[`F_COMP];
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gap_cnt_r <= 8'h00;
            gap_valid_r <= 1'b0;
            in_cal_r <= 1'b0;
            comp_active <= 1'b0;
            comp_cnt_r <= 8'h00;
            comp_timed_r <= 1'b0;
            blink_r <= 1'b0;
        end else begin
            if (tick_coarse)
                blink_r <= ~blink_r;
            if (gap_valid_r & tick_coarse) begin
                if (gap_cnt_r == `CAL_GAP_TICKS)
                    gap_valid_r <= 1'b0; // see [RULE7]
                else
                    gap_cnt_r <= gap_cnt_r + 8'h01;
            end
            if (cal_start) begin
                in_cal_r <= 1'b1;
                gap_valid_r <= 1'b0;
                if (comp_mode == `COMP_ON & gap_valid_r)
                    comp_active <= 1'b1; // see [RULE6]
            end
            if (cal_done & in_cal_r) begin
                in_cal_r <= 1'b0;
                // After a compensating run the pair is used up
                gap_valid_r <= ~comp_active;
                gap_cnt_r <= 8'h00;
                if (comp_mode == `COMP_ON)
                    comp_active <= 1'b0;
                if (comp_mode == `COMP_AUTO) begin
                    comp_active <= 1'b1; // see [RULE8]
                    comp_timed_r <= 1'b1;
                    comp_cnt_r <= 8'h00;
                end
            end
            if (comp_timed_r & tick_coarse) begin
                if (comp_cnt_r == `COMP_AUTO_TICKS - 8'h01) begin
                    comp_timed_r <= 1'b0;
                    comp_active <= 1'b0;
                end else begin
                    comp_cnt_r <= comp_cnt_r + 8'h01;
                end
            end
            if (comp_mode == `COMP_OFF) begin
                comp_active <= 1'b0; // see [RULE5]
                comp_timed_r <= 1'b0;
            end
        end
    end

    assign led_output = comp_active ? blink_r : heat_on; // see [RULE9]

    // Reported temperature; analog path never sees the hold
    reg [9:0] held_r;
    reg held_valid_r;
    reg [7:0] hold_cnt_r;
    reg hold_run_r;
    wire [1:0] hold_mode = ctrl_r[`F_HOLD];
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            held_r <= 10'h000;
            held_valid_r <= 1'b0;
            hold_cnt_r <= 8'h00;
            hold_run_r <= 1'b0;
            analog_actual <= 10'h000;
            display_temp <= 10'h000;
        end else begin
            analog_actual <= comp_active ? 10'h000 :
                actual_temp; // see [RULE9] [RULE19]
            if (start_fall) begin
                held_r <= actual_temp; // see [RULE17]
                held_valid_r <= 1'b1;
                hold_run_r <= 1'b1;
                hold_cnt_r <= 8'h00;
            end else if (hold_run_r & tick_coarse) begin
                if (hold_cnt_r == `HOLD_TICKS - 8'h01)
                    hold_run_r <= 1'b0; // see [RULE18]
                else
                    hold_cnt_r <= hold_cnt_r + 8'h01;
            end
            case (hold_mode)
                `HOLD_ON: display_temp <= held_valid_r ? held_r :
                    actual_temp; // see [RULE17]
                `HOLD_2S: display_temp <= hold_run_r ? held_r :
                    actual_temp; // see [RULE18]
                default: display_temp <= actual_temp; // see [RULE16]
            endcase
        end
    end
    // Analog output is driven from live value, or zero while compensating  see [RULE19]
endmodule
`default_nettype wire

// file: tb/sup_monitor.sv
// Port-level checks for the heatseal supervisor
`timescale 1ns/1ps
`default_nettype none
module sup_monitor #(
    parameter integer FINE_CYC = 1000,
    parameter integer COARSE_DIV = 1000
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [9:0] actual_temp,
    input wire logic heat_on,
    input wire logic cal_start,
    input wire logic cal_done,
    input wire logic meas_impulse,
    input wire logic comp_active,
    input wire logic led_output,
    input wire logic [9:0] analog_actual,
    input wire logic ext_diag_en,
    input wire logic dpv1_diag_int_en
);
    localparam integer TICK = FINE_CYC * COARSE_DIV;
    logic led_q;
    integer led_cnt, meas_cnt, cal_cnt;
    // Counters stand in for long repetitions the tools cannot unroll
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            led_q <= 1'b0;
            led_cnt <= 0;
            meas_cnt <= 0;
            cal_cnt <= 0;
        end else begin
            led_q <= led_output;
            led_cnt <= (comp_active && led_output == led_q) ? led_cnt + 1 : 0;
            meas_cnt <= meas_impulse ? meas_cnt + 1 : 0;
            cal_cnt <= (cal_start || cal_done) ? 0 : cal_cnt + 1;
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_diag_exclusive: assert property (
        !(ext_diag_en && dpv1_diag_int_en))
        else $error("legacy and interrupt diagnostics both on");
    a_led_follow: assert property (
        !comp_active |-> led_output == heat_on)
        else $error("indicator not following heating");
    a_led_blinks: assert property (led_cnt <= 2 * TICK + 2)
        else $error("indicator not blinking while compensating");
    a_analog_zero: assert property (
        comp_active && $past(comp_active) |-> analog_actual == 10'h000)
        else $error("analog not zero");
    a_analog_live: assert property (
        $past(hresetn) && !comp_active && !$past(comp_active)
        |-> analog_actual == $past(actual_temp))
        else $error("analog output not live");
    a_meas_width: assert property ($fell(meas_impulse)
        |-> meas_cnt >= 16 * FINE_CYC && meas_cnt <= 31 * FINE_CYC)
        else $error("measuring impulse length out of range");
    a_comp_cause: assert property (
        $rose(comp_active) |-> cal_cnt <= 22 * TICK)
        else $error("compensation without calibration");
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus not ready or error response");
endmodule
bind heatseal_supervisor sup_monitor #(
    .FINE_CYC(FINE_CYC), .COARSE_DIV(COARSE_DIV)
) mon (.hclk, .hresetn, .hreadyout, .hresp, .actual_temp, .heat_on,
    .cal_start, .cal_done, .meas_impulse, .comp_active, .led_output,
    .analog_actual, .ext_diag_en, .dpv1_diag_int_en);
`default_nettype wire

// file: tb/plc_model.sv
// Fieldbus master model: start bit and sealing band temperature
`timescale 1ns/1ps
`default_nettype none
module plc_model (
    input wire logic hclk,
    input wire logic go,
    input wire logic slow,
    input wire logic [15:0] hold_cyc,
    input wire logic [9:0] target,
    output logic start_pin,
    output logic [9:0] actual_temp
);
    logic [15:0] left;
    initial begin
        start_pin = 1'b0;
        actual_temp = 10'h014;
        left = 16'h0;
    end
    // A slow plant creeps one degree per clock towards its target
    always @(posedge hclk) begin
        left <= go ? hold_cyc : (left != 16'h0 ? left - 16'h1 : left);
        start_pin <= go || left > 16'h1;
        if (!slow || actual_temp == target)
            actual_temp <= target;
        else if (actual_temp < target)
            actual_temp <= actual_temp + 10'h1;
        else
            actual_temp <= actual_temp - 10'h1;
    end
endmodule
`default_nettype wire

// file: tb/tb.sv
// Self-checking bench for the heatseal supervisor
`timescale 1ns/1ps
`default_nettype none
`include "heatseal_map.vh"
`define CMP(nm, e, g) \
    begin \
        samples_checked++; \
        if ((g) !== (e)) begin \
            n_errors++; \
            $display("[ERR] %s expected %h seen %h", nm, e, g); \
        end \
    end
module tb;
    localparam integer FC = 4;
    localparam integer CD = 4;
    localparam integer TK = FC * CD;
    typedef struct packed {
        logic [7:0] ctl;
        logic [7:0] dly;
        logic [9:0] hup;
        logic [9:0] t0;
        logic [9:0] t1;
        logic [9:0] code;
    } dcase_t;
    logic hclk, hresetn, hsel, hwrite, heat_on, meas_req, cal_start;
    logic cal_done, hrdy, hresp, meas_impulse, alarm_relay, comp_active;
    logic ext_diag_en, dpv1_diag_int_en, start_pin, go, slow;
    logic [31:0] haddr, hwdata, hrdata, x;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [9:0] actual_temp, analog_actual, target, t, e;
    logic [15:0] hold_cyc;
    int n_errors, samples_checked, cyc, len, seen, c0;
    logic [7:0] ra[5] = '{`A_CTRL, `A_LIMITS, `A_TIMES, `A_MEAS, 8'h20};
    logic [31:0] rv[5] = '{32'h1, 32'h0a0a, 32'h0, 32'h11, 32'h0};
    logic [1:0] cm[4] = '{`COMP_OFF, `COMP_ON, `COMP_ON, `COMP_AUTO};
    int cg[4] = '{5, 5, 30, 30};
    logic ce[4] = '{1'b0, 1'b1, 1'b0, 1'b1};
    // Band edges avoided: 210 and 190 bound the window around 200
    dcase_t dc[10] = '{
        '{8'h48, 8'd0, 10'd0, 10'd200, 10'd215, `ERR_HIGH},
        '{8'h48, 8'd0, 10'd0, 10'd200, 10'd185, `ERR_LOW},
        '{8'h40, 8'd0, 10'd0, 10'd150, 10'd150, `ERR_NOARM_LOW},
        '{8'h4c, 8'd0, 10'd0, 10'd230, 10'd230, `ERR_NOARM_HIGH},
        '{8'h48, 8'd0, 10'd0, 10'd205, 10'd205, `ERR_NONE},
        '{8'h48, 8'd5, 10'd0, 10'd150, 10'd200, `ERR_NONE},
        '{8'h48, 8'd15, 10'd0, 10'd150, 10'd200, `ERR_NOARM_HIGH},
        '{8'h08, 8'd0, 10'd5, 10'd100, 10'd100, `ERR_HEATUP},
        '{8'h08, 8'd0, 10'd8, 10'd100, 10'd195, `ERR_NONE},
        '{8'h08, 8'd0, 10'd0, 10'd100, 10'd100, `ERR_NONE}};

    heatseal_supervisor #(.FINE_CYC(FC), .COARSE_DIV(CD)) uut (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hrdy), .hreadyout(hrdy), .hresp, .hrdata, .start_pin,
        .actual_temp, .heat_on, .meas_req, .cal_start, .cal_done,
        .meas_impulse, .alarm_relay, .comp_active, .led_output(),
        .analog_actual, .display_temp(), .ext_diag_en, .dpv1_diag_int_en);
    plc_model plc (.hclk, .go, .slow, .hold_cyc, .target, .start_pin,
        .actual_temp);

    function automatic logic [15:0] sw(input logic [15:0] w, input logic f);
        return f ? {w[7:0], w[15:8]} : w;
    endfunction
    function automatic logic [9:0] ecode(input logic [9:0] c, input logic w);
        return w ? c : (c != 10'h0 ? 10'h3 : 10'h0);
    endfunction
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge hclk); while (hrdy !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hrdy !== 1'b1);
        x = hrdata;
    endtask
    task automatic tk(input int n);
        repeat (n * TK) @(posedge hclk);
    endtask
    task automatic cal(input logic d);
        cal_done <= d;
        cal_start <= !d;
        @(posedge hclk);
        cal_done <= 1'b0;
        cal_start <= 1'b0;
    endtask
    // Start held n ticks; temperature moves to b four ticks in
    task automatic phase(input logic [9:0] a, input logic [9:0] b, input int n);
        target <= a;
        repeat (4) @(posedge hclk);
        go <= 1'b1;
        hold_cyc <= 16'(n * TK);
        @(posedge hclk);
        go <= 1'b0;
        tk(4);
        target <= b;
        tk(n - 2);
    endtask
    task close_out;
        if (n_errors == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        cyc++;
        if (comp_active === 1'b1)
            seen++;
        if (cyc == 40000) begin
            n_errors++;
            close_out();
        end
    end
    initial begin
        {hresetn, hsel, hwrite, heat_on, meas_req, cal_start} = '0;
        {cal_done, go, slow, haddr, hwdata, htrans, hold_cyc} = '0;
        target = 10'h014;
        hsize = 3'h2;
        void'($urandom(32'h1c71db39));
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        foreach (ra[i]) begin
            bus(1'b0, ra[i], 32'h0);
            `CMP("reset value", rv[i], x)
        end
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, `A_CTRL, i);
            @(posedge hclk);
            e = {8'h0, i[0] & ~i[1], i[0] & i[1]};
            `CMP("diag", e[1:0], {ext_diag_en, dpv1_diag_int_en})
        end
        for (int i = 0; i < 3; i++) begin
            t = (i == 0) ? 10'd17 : (i == 1) ? 10'd30 : 10'(17 + $urandom % 14);
            bus(1'b1, `A_MEAS, {22'h0, t});
            meas_req <= 1'b1;
            @(posedge hclk);
            meas_req <= 1'b0;
            len = 0;
            repeat (40 * FC) begin
                @(posedge hclk);
                len += (meas_impulse === 1'b1);
            end
            `CMP("pulse", 1'b1, len >= (t - 1) * FC && len <= t * FC + 1)
        end
        slow <= 1'b1;
        for (int f = 0; f < 2; f++) begin
            t = 10'($urandom);
            target <= t;
            heat_on <= 1'($urandom);
            bus(1'b1, `A_CTRL, 32'h1 | f << 2);
            repeat (1100) @(posedge hclk);
            bus(1'b0, `A_CYCIN, 32'h0);
            `CMP("cyclic", {16'h0, sw({6'h0, t}, f[0])}, x)
        end
        slow <= 1'b0;
        bus(1'b1, `A_LIMITS, 32'h0a0a);
        foreach (dc[i]) begin
            bus(1'b1, `A_CTRL, {24'h0, dc[i].ctl});
            bus(1'b1, `A_TIMES, {6'h0, dc[i].hup, 9'h0, dc[i].dly[6:0]});
            bus(1'b1, `A_SETPT, {16'h0, sw(16'd200, dc[i].ctl[2])});
            bus(1'b1, `A_CLEAR, 32'h1);
            heat_on <= 1'($urandom);
            phase(dc[i].t0, dc[i].t1, 14);
            bus(1'b0, `A_STATUS, 32'h0);
            e = ecode(dc[i].code, dc[i].ctl[3]);
            `CMP("err", e, x[9:0])
            e = {8'h0, {2{dc[i].code != 10'h0}}};
            `CMP("alarm", e[1:0], {alarm_relay, x[13]})
        end
        // Second reset: hold mode must start out live again
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        bus(1'b1, `A_CTRL, 32'h101);
        target <= 10'd120;
        repeat (6) @(posedge hclk);
        bus(1'b0, `A_CYCIN, 32'h0);
        `CMP("live", 32'd120, x)
        phase(10'd300, 10'd50, 3);
        bus(1'b0, `A_CYCIN, 32'h0);
        `CMP("held", 32'd300, x)
        bus(1'b1, `A_CTRL, 32'h201);
        phase(10'd260, 10'd80, 3);
        bus(1'b0, `A_CYCIN, 32'h0);
        `CMP("two second hold", 32'd260, x)
        tk(25);
        bus(1'b0, `A_CYCIN, 32'h0);
        `CMP("after hold", 32'd80, x)
        `CMP("analog", 10'd80, analog_actual)
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, `A_CTRL, {26'h0, cm[i], 4'h1});
            c0 = seen;
            cal(1'b0);
            repeat (5) @(posedge hclk);
            cal(1'b1);
            tk(cg[i]);
            cal(1'b0);
            tk(10);
            cal(1'b1);
            tk(25);
            `CMP("compensation", ce[i], seen != c0)
        end
        close_out();
    end
endmodule
`default_nettype wire
